// [hdl/sdram_bank_array.v]
// one bank of storage with byte write enables and a registered read port
`timescale 1ns/100ps
`default_nettype none
module sdram_bank_array #(
  parameter ADDR_BITS = 17,
  parameter DATA_BITS = 16
) (
  // clock and enable
  input  wire                 clk_sys,
  input  wire                 en,
  // access
  input  wire [ADDR_BITS-1:0] addr,
  input  wire                 read_en,
  input  wire [1:0]           write_byte,
  input  wire [DATA_BITS-1:0] wdata,
  output reg  [DATA_BITS-1:0] rdata
);

  localparam DEPTH = 1 << ADDR_BITS;
  localparam HALF  = DATA_BITS / 2;

  reg [DATA_BITS-1:0] mem [0:DEPTH-1];

  // byte-wise write, registered read; data storage has no reset
  always @(posedge clk_sys) begin
    if (en) begin
      if (write_byte[0]) begin
        mem[addr][HALF-1:0] <= wdata[HALF-1:0];
      end
      if (write_byte[1]) begin
        mem[addr][DATA_BITS-1:HALF] <= wdata[DATA_BITS-1:HALF];
      end
      if (read_en) begin
        rdata <= mem[addr];
      end
    end
  end

endmodule
`default_nettype wire

// [hdl/sdram_burst_addr.v]
// burst column generator: sequential or interleaved order inside the burst window
`timescale 1ns/100ps
`default_nettype none
module sdram_burst_addr #(
  parameter COL_BITS = 8
) (
  // burst description
  input  wire [COL_BITS-1:0] start_col,
  input  wire [COL_BITS-1:0] index,
  input  wire [COL_BITS-1:0] len_mask,
  input  wire                interleave,
  // resulting column
  output wire [COL_BITS-1:0] col
);

  wire [COL_BITS-1:0] seq_low;
  wire [COL_BITS-1:0] int_low;

  // low bits step or flip inside the window, high bits stay fixed
  assign seq_low = start_col + index;
  assign int_low = start_col ^ index;
  assign col     = (start_col & ~len_mask) | ((interleave ? int_low : seq_low) & len_mask);

endmodule
`default_nettype wire

// [hdl/sdram_device.v]
// two-bank sdram device: command decode, bank state, burst engine and data pins
//
// Overview of operation
// - inputs except clock gate sampled on rising edge
// - two banks of 131072 sixteen-bit words
// - banks keep own open row, work independently
// - activate takes row from address bits 0-8
// - read/write takes column from address bits 0-7
// - bank select low bank 0, high bank 1
// - precharge one bank, or both when select high
// - precharge select on read/write: auto precharge after burst
// - mode set stores all ten address bits
// - command decoded from row, column, write strobes
// - commands accepted only while chip select low
// - chip select high keeps internal state unchanged (here a running burst still steps and may auto precharge)
// - clock gate high makes next edge valid (here only after four edges sampled high)
// - gate low: power-down, suspend or self refresh
// - clock gate treated as asynchronous input
// - burst lengths 1, 2, 4, 8, full page
// - burst order sequential or interleaved
// - read latency two or three clocks
// - new random column accepted every cycle
// - burst write or single-word write mode
// - data pins controlled per byte by masks
// - masked byte is not written
// - masked read byte goes high impedance
`include "sdram_device_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module sdram_device #(
  parameter ROW_BITS  = 9,
  parameter COL_BITS  = 8,
  parameter DATA_BITS = 16
) (
  // clock, reset, freeze
  input  wire                 clk_sys,
  input  wire                 rst_n,
  input  wire                 ce,
  // command pins
  input  wire                 clock_gate,
  input  wire                 cs_n,
  input  wire                 ras_n,
  input  wire                 cas_n,
  input  wire                 we_n,
  input  wire [9:0]           addr,
  // data pins
  input  wire                 low_byte_mask,
  input  wire                 high_byte_mask,
  input  wire [DATA_BITS-1:0] dq_in,
  output reg  [DATA_BITS-1:0] dq_out,
  output reg                  dq_oe_low,
  output reg                  dq_oe_high,
  // status
  output reg  [1:0]           bank_open,
  output reg  [1:0]           power_mode,
  output reg  [9:0]           mode_word,
  output reg                  burst_active
);

  localparam ARR_BITS = ROW_BITS + COL_BITS;

  // burst length in words for a length code
  function [COL_BITS:0] burst_len;
    input [2:0] code;
    begin
      case (code)
        `LEN_1:    burst_len = {{COL_BITS{1'b0}}, 1'b1};
        `LEN_2:    burst_len = {{(COL_BITS-1){1'b0}}, 2'h2};
        `LEN_4:    burst_len = {{(COL_BITS-2){1'b0}}, 3'h4};
        `LEN_8:    burst_len = {{(COL_BITS-3){1'b0}}, 4'h8};
        `LEN_PAGE: burst_len = {1'b1, {COL_BITS{1'b0}}};
        default:   burst_len = {{COL_BITS{1'b0}}, 1'b1};
      endcase
    end
  endfunction

  // clock gate synchroniser; s1 feeds only s2
  reg cke_s1;
  reg cke_s2;
  reg cke_s3;
  reg cke_ok;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cke_s1 <= 1'b0;
      cke_s2 <= 1'b0;
      cke_s3 <= 1'b0;
      cke_ok <= 1'b0;
    end else if (ce) begin
      cke_s1 <= clock_gate;
      cke_s2 <= cke_s1;
      cke_s3 <= cke_s2;
      if (cke_s2 == cke_s3) begin
        cke_ok <= cke_s3;
      end
    end
  end

  // edge qualification and command decode
  wire       edge_ok  = ce & cke_ok;
  wire       cmd_sel  = edge_ok & ~cs_n;
  wire [2:0] cmd      = {ras_n, cas_n, we_n};
  wire       is_mrs   = cmd_sel & (cmd == `CMD_MODE_SET);
  wire       is_ref   = cmd_sel & (cmd == `CMD_REFRESH);
  wire       is_pre   = cmd_sel & (cmd == `CMD_PRECHARGE);
  wire       is_act   = cmd_sel & (cmd == `CMD_ACTIVATE);
  wire       is_wr    = cmd_sel & (cmd == `CMD_WRITE);
  wire       is_rd    = cmd_sel & (cmd == `CMD_READ);
  wire       is_stop  = cmd_sel & (cmd == `CMD_BURST_STOP);
  wire       col_cmd  = is_rd | is_wr;
  wire       pre_sel  = addr[`ADDR_PRE_SEL];
  wire       bank_sel = addr[`ADDR_BANK_SEL];

  // mode word fields
  wire [2:0] len_code   = mode_word[`MODE_LEN_MSB:`MODE_LEN_LSB];
  wire       interleave = mode_word[`MODE_ORDER] & (len_code != `LEN_PAGE);
  wire       lat3       = mode_word[`MODE_LAT_MSB:`MODE_LAT_LSB] == `LAT_3;
  wire       wr_single  = mode_word[`MODE_WRITE_SINGLE];

  // length of a newly started burst; single write mode forces one word
  wire [COL_BITS:0] new_len  = (is_wr & wr_single) ? burst_len(`LEN_1) : burst_len(len_code);
  wire [COL_BITS:0] new_last = new_len - 1'b1;

  // burst engine state
  reg                busy;
  reg                bwrite;
  reg                bbank;
  reg                bauto;
  reg                bfull;
  reg [COL_BITS-1:0] bstart;
  reg [COL_BITS-1:0] bidx;
  reg [COL_BITS-1:0] blast;
  reg [COL_BITS-1:0] bmask;
  reg                binter;
  wire [COL_BITS-1:0] gen_col;

  sdram_burst_addr #(
    .COL_BITS (COL_BITS)
  ) u_burst_addr (
    .start_col  (bstart),
    .index      (bidx),
    .len_mask   (bmask),
    .interleave (binter),
    .col        (gen_col)
  );

  // bank rows
  reg [ROW_BITS-1:0] bank_row0;
  reg [ROW_BITS-1:0] bank_row1;

  // current array access: new column command wins over the running burst
  wire                terminate  = is_pre | is_stop;
  wire                burst_step = busy & edge_ok & ~col_cmd & ~terminate;
  wire                acc_now    = col_cmd | burst_step;
  wire                acc_bank   = col_cmd ? bank_sel : bbank;
  wire [COL_BITS-1:0] acc_col    = col_cmd ? addr[COL_BITS-1:0] : gen_col;
  wire                acc_write  = col_cmd ? is_wr : bwrite;
  wire [ROW_BITS-1:0] acc_row    = acc_bank ? bank_row1 : bank_row0;
  wire                acc_ok     = acc_now & (acc_bank ? bank_open[1] : bank_open[0]);
  wire [ARR_BITS-1:0] arr_addr   = {acc_row, acc_col};
  wire                acc_read   = acc_ok & ~acc_write;
  wire [1:0]          wr_bytes   = {2{acc_ok & acc_write}} & ~{high_byte_mask, low_byte_mask};

  // end of a natural burst and the auto precharge it may carry
  wire burst_end  = burst_step & ~bfull & (bidx == blast);
  wire close_now  = col_cmd & pre_sel & (new_len == burst_len(`LEN_1));
  wire close_end  = burst_end & bauto;
  wire close_bank = close_now ? bank_sel : bbank;

  // mode register set takes the whole address including bank select
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_word <= `MODE_RESET;
    end else if (is_mrs) begin
      mode_word <= addr;
    end
  end

  // burst engine: load on column command, step each valid edge, stop on end
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy   <= 1'b0;
      bwrite <= 1'b0;
      bbank  <= 1'b0;
      bauto  <= 1'b0;
      bfull  <= 1'b0;
      binter <= 1'b0;
      bstart <= {COL_BITS{1'b0}};
      bidx   <= {COL_BITS{1'b0}};
      blast  <= {COL_BITS{1'b0}};
      bmask  <= {COL_BITS{1'b0}};
    end else if (col_cmd) begin
      busy   <= new_len != burst_len(`LEN_1);
      bwrite <= is_wr;
      bbank  <= bank_sel;
      bauto  <= pre_sel;
      bfull  <= (len_code == `LEN_PAGE) & ~(is_wr & wr_single);
      binter <= interleave;
      bstart <= addr[COL_BITS-1:0];
      bidx   <= {{(COL_BITS-1){1'b0}}, 1'b1};
      blast  <= new_last[COL_BITS-1:0];
      bmask  <= new_last[COL_BITS-1:0];
    end else if (busy & edge_ok) begin
      if (terminate | burst_end) begin
        busy <= 1'b0;
      end else begin
        bidx <= bidx + {{(COL_BITS-1){1'b0}}, 1'b1};
      end
    end
  end

  // per-bank open state and row, each bank updated on its own
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bank_open <= 2'h0;
      bank_row0 <= {ROW_BITS{1'b0}};
      bank_row1 <= {ROW_BITS{1'b0}};
    end else if (edge_ok) begin
      if (is_act & ~bank_sel) begin
        bank_open[0] <= 1'b1;
        bank_row0    <= addr[ROW_BITS-1:0];
      end
      if (is_act & bank_sel) begin
        bank_open[1] <= 1'b1;
        bank_row1    <= addr[ROW_BITS-1:0];
      end
      if ((is_pre & (pre_sel | ~bank_sel)) | ((close_now | close_end) & ~close_bank)) begin
        bank_open[0] <= 1'b0;
      end
      if ((is_pre & (pre_sel | bank_sel)) | ((close_now | close_end) & close_bank)) begin
        bank_open[1] <= 1'b0;
      end
    end
  end

  // two bank arrays
  wire [DATA_BITS-1:0] rd0;
  wire [DATA_BITS-1:0] rd1;

  sdram_bank_array #(
    .ADDR_BITS (ARR_BITS),
    .DATA_BITS (DATA_BITS)
  ) u_bank0 (
    .clk_sys    (clk_sys),
    .en         (edge_ok),
    .addr       (arr_addr),
    .read_en    (acc_read & ~acc_bank),
    .write_byte (wr_bytes & {2{~acc_bank}}),
    .wdata      (dq_in),
    .rdata      (rd0)
  );

  sdram_bank_array #(
    .ADDR_BITS (ARR_BITS),
    .DATA_BITS (DATA_BITS)
  ) u_bank1 (
    .clk_sys    (clk_sys),
    .en         (edge_ok),
    .addr       (arr_addr),
    .read_en    (acc_read & acc_bank),
    .write_byte (wr_bytes & {2{acc_bank}}),
    .wdata      (dq_in),
    .rdata      (rd1)
  );

  // read pipeline: valid flags and bank of the word in flight
  reg                 rd_v0;
  reg                 rd_b0;
  reg                 p1_v;
  reg [DATA_BITS-1:0] p1_d;
  reg [1:0]           mask_q;
  wire [DATA_BITS-1:0] arr_rd = rd_b0 ? rd1 : rd0;
  wire                 out_v  = lat3 ? p1_v : rd_v0;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_v0  <= 1'b0;
      rd_b0  <= 1'b0;
      p1_v   <= 1'b0;
      p1_d   <= {DATA_BITS{1'b0}};
      mask_q <= 2'h3;
    end else if (edge_ok) begin
      rd_v0  <= acc_read;
      rd_b0  <= acc_bank;
      p1_v   <= rd_v0;
      p1_d   <= arr_rd;
      mask_q <= {high_byte_mask, low_byte_mask};
    end
  end

  // data pin drivers: latency tap, byte enables off while masked
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dq_out     <= {DATA_BITS{1'b0}};
      dq_oe_low  <= 1'b0;
      dq_oe_high <= 1'b0;
    end else if (edge_ok) begin
      dq_out     <= lat3 ? p1_d : arr_rd;
      dq_oe_low  <= out_v & ~mask_q[0];
      dq_oe_high <= out_v & ~mask_q[1];
    end
  end

  // last accepted command, used to tell self refresh from power-down;
  // deselected edges leave it alone so idle cycles do not hide a refresh
  reg last_refresh;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last_refresh <= 1'b0;
    end else if (cmd_sel) begin
      last_refresh <= is_ref;
    end
  end

  // power state: chosen from prior activity when the clock gate falls
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power_mode <= `PM_RUN;
    end else if (ce) begin
      case (power_mode)
        `PM_RUN: begin
          if (!cke_ok) begin
            if (last_refresh) begin
              power_mode <= `PM_SELF_REFRESH;
            end else if (busy | rd_v0 | p1_v) begin
              power_mode <= `PM_SUSPEND;
            end else begin
              power_mode <= `PM_POWER_DOWN;
            end
          end
        end
        `PM_POWER_DOWN, `PM_SUSPEND, `PM_SELF_REFRESH: begin
          if (cke_ok) begin
            power_mode <= `PM_RUN;
          end
        end
        default: begin
          power_mode <= `PM_RUN;
        end
      endcase
    end
  end

  // burst status pin
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      burst_active <= 1'b0;
    end else if (ce) begin
      burst_active <= busy;
    end
  end

endmodule
`default_nettype wire

// [hdl/sdram_device_regs.vh]
// command codes, mode word fields and address bit positions of the sdram device
`ifndef SDRAM_DEVICE_REGS_VH
`define SDRAM_DEVICE_REGS_VH

// command codes, taken as {row strobe, column strobe, write strobe}, all active low
`define CMD_MODE_SET     3'h0
`define CMD_REFRESH      3'h1
`define CMD_PRECHARGE    3'h2
`define CMD_ACTIVATE     3'h3
`define CMD_WRITE        3'h4
`define CMD_READ         3'h5
`define CMD_BURST_STOP   3'h6
`define CMD_NOP          3'h7

// address bit positions with a fixed meaning
`define ADDR_PRE_SEL     8
`define ADDR_BANK_SEL    9

// mode setting word layout
`define MODE_LEN_LSB     0
`define MODE_LEN_MSB     2
`define MODE_ORDER       3
`define MODE_LAT_LSB     4
`define MODE_LAT_MSB     6
`define MODE_WRITE_SINGLE 9
`define MODE_RESET       10'h020

// burst length codes
`define LEN_1            3'h0
`define LEN_2            3'h1
`define LEN_4            3'h2
`define LEN_8            3'h3
`define LEN_PAGE         3'h7

// read latency codes
`define LAT_2            3'h2
`define LAT_3            3'h3

// power states
`define PM_RUN           2'h0
`define PM_POWER_DOWN    2'h1
`define PM_SUSPEND       2'h2
`define PM_SELF_REFRESH  2'h3

`endif

// [verification/sdram_ctrl_model.sv]
// memory controller model that drives the sdram command and data pins
`timescale 1ns/100ps
`default_nettype none
module sdram_ctrl_model (
  // clock
  input  wire logic        clk_sys,
  // command pins
  output var  logic        cs_n,
  output var  logic        ras_n,
  output var  logic        cas_n,
  output var  logic        we_n,
  output var  logic [9:0]  addr,
  // data pins
  output var  logic        low_byte_mask,
  output var  logic        high_byte_mask,
  output var  logic [15:0] dq_in
);
  // deselected and idle at time zero
  initial begin
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    addr = 10'h000;
    {high_byte_mask, low_byte_mask} = 2'h0;
    dq_in = 16'h0000;
  end
  // one command for one edge, changed just after a rising edge
  task go(input logic s, input logic [2:0] c, input logic [9:0] a, input logic [1:0] m, input logic [15:0] d);
    @(posedge clk_sys);
    cs_n <= s;
    {ras_n, cas_n, we_n} <= c;
    addr <= a;
    {high_byte_mask, low_byte_mask} <= m;
    dq_in <= d;
  endtask
  // command then no-operation; released data lines show the inverse
  task issue(input logic [2:0] c, input logic [9:0] a, input logic [1:0] m, input logic [15:0] d);
    go(1'b0, c, a, m, d);
    go(1'b0, 3'h7, 10'h000, 2'h0, ~d);
  endtask
  // slow controller: deselected cycles, data lines toggling
  task idle(input int n);
    repeat (n) go(1'b1, 3'h7, 10'h000, 2'h0, ~dq_in);
  endtask
  // refresh that keeps the rows alive
  task refresh();
    go(1'b0, 3'h1, 10'h000, 2'h0, ~dq_in);
  endtask
endmodule
`default_nettype wire

// [verification/sdram_device_chk.sv]
// checker for the sdram device command, data and power pins
`timescale 1ns/100ps
`default_nettype none
module sdram_device_chk (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // controller side
  input wire logic       ce,
  input wire logic       clock_gate,
  input wire logic       cs_n,
  input wire logic       ras_n,
  input wire logic       cas_n,
  input wire logic       we_n,
  input wire logic [9:0] addr,
  input wire logic       low_byte_mask,
  input wire logic       high_byte_mask,
  // device side
  input wire logic       dq_oe_low,
  input wire logic       dq_oe_high,
  input wire logic [1:0] bank_open,
  input wire logic [1:0] power_mode,
  input wire logic [9:0] mode_word
);
  logic [2:0] gate_run;
  wire        vld  = ce && gate_run[2];
  wire [2:0]  cmd  = {ras_n, cas_n, we_n};
  wire        take = vld && !cs_n;
  // edges seen with the gate high; four of them make an edge surely valid
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      gate_run <= 3'h0;
    else if (ce)
      gate_run <= !clock_gate ? 3'h0 : (gate_run[2] ? gate_run : gate_run + 3'h1);
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_act_opens_bank: assert property (take && cmd == 3'h3 |=> bank_open[$past(addr[9])])
    else $error("activate left the bank closed");
  a_pre_one_bank: assert property (take && cmd == 3'h2 && !addr[8] |=> !bank_open[$past(addr[9])])
    else $error("precharge left the selected bank open");
  a_pre_all_banks: assert property (take && cmd == 3'h2 && addr[8] |=> bank_open == 2'h0)
    else $error("precharge all left a bank open");
  a_mode_load: assert property (take && cmd == 3'h0 |=> mode_word == $past(addr))
    else $error("mode word not loaded from address");
  a_desel_hold: assert property (cs_n |=> $stable(mode_word) && (bank_open & ~$past(bank_open)) == 2'h0)
    else $error("state changed while deselected");
  a_auto_close: assert property (take && cmd == 3'h4 && addr[8] && mode_word[2:0] == 3'h0
    && bank_open[addr[9]] |=> !bank_open[$past(addr[9])])
    else $error("auto precharge did not close the bank");
  a_mask_low_hiz: assert property (vld && low_byte_mask ##1 vld |=> !dq_oe_low)
    else $error("masked low byte driven");
  a_mask_high_hiz: assert property (vld && high_byte_mask ##1 vld |=> !dq_oe_high)
    else $error("masked high byte driven");
  a_read_short: assert property (take && cmd == 3'h5 && bank_open[addr[9]] && mode_word[6:4] != 3'h3
    && !low_byte_mask ##1 vld |=> dq_oe_low)
    else $error("short latency read data missing");
  a_read_long: assert property (take && cmd == 3'h5 && bank_open[addr[9]] && mode_word[6:4] == 3'h3
    ##1 vld && !low_byte_mask ##1 vld |=> dq_oe_low)
    else $error("long latency read data missing");
  a_gate_sleep: assert property (vld ##1 (ce && !clock_gate) [*8] |-> power_mode != 2'h0)
    else $error("gate low but device still running");
  a_gate_wake: assert property ((ce && clock_gate) [*8] |-> power_mode == 2'h0)
    else $error("gate high but device not running");
  c_read: cover property (take && cmd == 3'h5);
  c_auto_pre: cover property (take && cmd == 3'h4 && addr[8]);
  c_self_refresh: cover property (power_mode == 2'h3);
endmodule
`default_nettype wire

// [verification/test_sdram_device.sv]
// testbench for the sdram device driven through the controller model
`timescale 1ns/100ps
`default_nettype none
module test_sdram_device;
  logic             clk_sys;
  logic             rst_n;
  logic             ce;
  logic             clock_gate;
  wire logic        cs_n, ras_n, cas_n, we_n, low_byte_mask, high_byte_mask;
  wire logic [9:0]  addr;
  wire logic [15:0] dq_in;
  wire logic [15:0] dq_out;
  wire logic        dq_oe_low, dq_oe_high, burst_active;
  wire logic [1:0]  bank_open, power_mode;
  wire logic [9:0]  mode_word;
  int               fail_count;
  int               tests_run;
  sdram_ctrl_model ctl (.clk_sys(clk_sys), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .addr(addr), .low_byte_mask(low_byte_mask), .high_byte_mask(high_byte_mask), .dq_in(dq_in));
  sdram_device dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .clock_gate(clock_gate), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr), .low_byte_mask(low_byte_mask),
    .high_byte_mask(high_byte_mask), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_low(dq_oe_low),
    .dq_oe_high(dq_oe_high), .bank_open(bank_open), .power_mode(power_mode), .mode_word(mode_word),
    .burst_active(burst_active));
  // 200 MHz clock
  initial clk_sys = 1'b0;
  always #2.5 clk_sys = ~clk_sys;
  // word stored at a bank and column
  function automatic logic [15:0] pat(input logic b, input logic [7:0] c);
    return {3'h5, b, c[3:0], c ^ 8'h3c};
  endfunction
  // compare; callers wait for outputs to settle before the call
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // eight-word read, checked word by word in sequential or interleaved order
  task rd(input logic b, input logic [7:0] c, input logic il);
    ctl.issue(3'h5, {b, 1'b0, c}, 2'h0, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      #1 chk(dq_out, pat(b, {c[7:3], il ? c[2:0] ^ i[2:0] : c[2:0] + i[2:0]}));
      chk({15'h0, burst_active}, {15'h0, i != 7});
    end
  endtask
  // gate low for a while with a command that must be ignored, then wake
  task nap(input logic [1:0] pm);
    @(posedge clk_sys);
    clock_gate <= 1'b0;
    ctl.idle(4);
    ctl.issue(3'h3, 10'h005, 2'h0, 16'h0000);
    ctl.idle(8);
    #1 chk({14'h0, power_mode}, {14'h0, pm});
    @(posedge clk_sys);
    clock_gate <= 1'b1;
    ctl.idle(8);
    #1 chk({12'h0, power_mode, bank_open}, 16'h0000);
  endtask
  task summarize();
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count = fail_count + 1;
    summarize();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    clock_gate = 1'b1;
    fail_count = 0;
    tests_run = 0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 chk({2'h0, mode_word, bank_open, power_mode}, 16'h0200);
    repeat (4) @(posedge clk_sys);
    ctl.issue(3'h0, 10'h223, 2'h0, 16'h0000);
    #1 chk({6'h0, mode_word}, 16'h0223);
    ctl.issue(3'h3, 10'h005, 2'h0, 16'h0000);
    ctl.issue(3'h3, 10'h209, 2'h0, 16'h0000);
    #1 chk({14'h0, bank_open}, 16'h0003);
    for (int b = 0; b < 2; b++)
      for (int c = 0; c < 8; c++)
        ctl.issue(3'h4, {b[0], 1'b0, c[7:0]}, 2'h0, pat(b[0], c[7:0]));
    rd(1'b0, 8'h03, 1'b0);
    rd(1'b1, 8'h06, 1'b0);
    ctl.issue(3'h0, 10'h22b, 2'h0, 16'h0000);
    rd(1'b0, 8'h05, 1'b1);
    // single words back to back on both banks
    ctl.issue(3'h0, 10'h020, 2'h0, 16'h0000);
    ctl.go(1'b0, 3'h5, 10'h001, 2'h0, 16'h0000);
    ctl.issue(3'h5, 10'h207, 2'h0, 16'h0000);
    #1 chk(dq_out, pat(1'b0, 8'h01));
    @(posedge clk_sys);
    #1 chk(dq_out, pat(1'b1, 8'h07));
    // byte masks on write and read
    ctl.issue(3'h4, 10'h002, 2'h2, 16'hffff);
    ctl.issue(3'h5, 10'h002, 2'h0, 16'h0000);
    @(posedge clk_sys);
    #1 chk(dq_out, 16'ha2ff);
    ctl.issue(3'h5, 10'h002, 2'h1, 16'h0000);
    @(posedge clk_sys);
    #1 chk({14'h0, dq_oe_high, dq_oe_low}, 16'h0002);
    // three-clock latency
    ctl.issue(3'h0, 10'h030, 2'h0, 16'h0000);
    ctl.issue(3'h5, 10'h004, 2'h0, 16'h0000);
    @(posedge clk_sys);
    #1 chk({15'h0, dq_oe_low}, 16'h0000);
    @(posedge clk_sys);
    #1 chk(dq_out, pat(1'b0, 8'h04));
    // deselected precharge, then single and all-bank precharge
    ctl.go(1'b1, 3'h2, 10'h100, 2'h0, 16'h0000);
    ctl.idle(1);
    #1 chk({14'h0, bank_open}, 16'h0003);
    ctl.issue(3'h2, 10'h200, 2'h0, 16'h0000);
    #1 chk({14'h0, bank_open}, 16'h0001);
    ctl.issue(3'h2, 10'h100, 2'h0, 16'h0000);
    #1 chk({14'h0, bank_open}, 16'h0000);
    ctl.issue(3'h3, 10'h005, 2'h0, 16'h0000);
    ctl.issue(3'h4, 10'h100, 2'h0, pat(1'b0, 8'h00));
    #1 chk({14'h0, bank_open}, 16'h0000);
    nap(2'h1);
    ctl.refresh();
    nap(2'h3);
    summarize();
  end
endmodule
bind sdram_device sdram_device_chk chk (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .clock_gate(clock_gate),
  .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr), .low_byte_mask(low_byte_mask),
  .high_byte_mask(high_byte_mask), .dq_oe_low(dq_oe_low), .dq_oe_high(dq_oe_high), .bank_open(bank_open),
  .power_mode(power_mode), .mode_word(mode_word));
`default_nettype wire
